// ---- rtl/bts_pkg.sv ----
/*
  Shared constants and carrier types for the block transfer and swap sequencer.
  Assumes a single clock and an APB master for the control registers.
*/
package bts_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] base_off = 8'h04;
  localparam logic [7:0] status_off = 8'h08;
  localparam logic [7:0] result_off = 8'h0c;
  localparam logic [7:0] regsel_off = 8'h10;
  localparam logic [7:0] regval_off = 8'h14;
  localparam logic [7:0] swapsrc_off = 8'h18;
  localparam logic [7:0] saved_off = 8'h1c;
  localparam logic [7:0] curstat_off = 8'h20;
  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int list_lsb = 0;
  localparam int load_bit = 16;
  localparam int pre_bit = 17;
  localparam int up_bit = 18;
  localparam int wb_bit = 19;
  localparam int s_bit = 20;
  localparam int byte_bit = 21;
  localparam int swap_bit = 22;
  localparam int go_bit = 31;
  localparam int pc_index = 15;
  localparam int base_idx_lsb = 24;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [31:0] word_reset = 32'h0000_0000;
  localparam logic [4:0] fetch_pc_count = 5'h03;
  localparam logic [4:0] fetch_count = 5'h01;

  typedef enum logic [2:0] {
    st_idle, st_fetch, st_xfer, st_internal, st_swap_rd, st_swap_wr
  } phase_type;

  // Memory side of the sequencer
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic req;
    logic lock;
    logic byte_size;
  } mem_req_type;
endpackage : bts_pkg

// ---- rtl/block_transfer_swap_unit.sv ----
/*
  Sequencer for block load/store and atomic swap, with APB control registers
  and a small register bank. Assumes the memory answers each transfer in the
  cycle it is driven (mem_rdata and abort valid in the same cycle).
*/
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module block_transfer_swap_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory side
  output bts_pkg::mem_req_type mem_out,
  input wire logic [31:0] mem_rdata,
  input wire logic abort,
  // Status
  output logic data_abort_trap,
  output logic busy
);
  import bts_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_type phase;
    logic [31:0] ctrl;
    logic [31:0] base_init;
    logic [31:0] addr;
    logic [31:0] wb_val;
    logic [15:0] left;
    logic [4:0] fetches;
    logic [4:0] cyc;
    logic aborted;
    logic [31:0] swap_rd;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trap;
    logic [3:0] sel;
    logic [31:0] saved_stat;
    logic [31:0] cur_stat;
    logic user_bank;
    logic busy;
    mem_req_type mem;
  } state_type;

  state_type s_r, s_nxt;
  logic [31:0] bank_r [16];
  logic [31:0] bank_nxt [16];

  // Lowest set bit of a list; the order of transfer
  function automatic logic [3:0] lowest(input logic [15:0] l);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (l[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [31:0] popcnt4(input logic [15:0] l);
    logic [31:0] n;
    n = 32'h0;
    for (int i = 0; i < 16; i++) begin
      n = n + {29'h0, l[i], 2'b00};
    end
    return n;
  endfunction

  logic [3:0] cur_reg;
  logic [3:0] base_idx;
  logic is_load;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] span;
  logic [31:0] start_addr;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    bank_nxt = bank_r;
    base_idx = s_r.ctrl[base_idx_lsb +: 4];
    is_load = s_r.ctrl[load_bit];
    cur_reg = lowest(s_r.left);
    span = popcnt4(pwdata[15:0]);
    start_addr = 32'h0;
    apb_wr = psel && penable && pwrite && !s_r.pready;
    apb_rd = psel && penable && !pwrite && !s_r.pready;
    s_nxt.pready = psel && penable && !s_r.pready;
    s_nxt.pslverr = 1'b0;
    s_nxt.mem.req = 1'b0;
    s_nxt.mem.write = 1'b0;
    s_nxt.mem.lock = 1'b0;
    s_nxt.trap = 1'b0;

    // APB register access; writes to ctrl with the go bit set start an instruction when idle
    if (apb_rd) begin
      unique case (paddr)
        ctrl_off: s_nxt.prdata = s_r.ctrl;
        base_off: s_nxt.prdata = bank_r[base_idx];
        status_off: s_nxt.prdata = {29'h0, s_r.user_bank, s_r.aborted,
                                    s_r.phase != st_idle};
        result_off: s_nxt.prdata = s_r.swap_rd;
        regval_off: s_nxt.prdata = bank_r[s_r.sel];
        saved_off: s_nxt.prdata = s_r.saved_stat;
        curstat_off: s_nxt.prdata = s_r.cur_stat;
        regsel_off: s_nxt.prdata = {28'h0, s_r.sel};
        default: begin
          s_nxt.prdata = word_reset;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_wr) begin
      if (s_r.phase != st_idle && paddr != regsel_off) begin
        s_nxt.pslverr = 1'b1; // Busy: refuse state changes mid-instruction
      end else begin
        unique case (paddr)
          regsel_off: s_nxt.sel = pwdata[3:0];
          regval_off: bank_nxt[s_r.sel] = pwdata;
          saved_off: s_nxt.saved_stat = pwdata;
          curstat_off: s_nxt.cur_stat = pwdata;
          ctrl_off: begin
            s_nxt.ctrl = pwdata;
            if (pwdata[go_bit]) begin
              s_nxt.aborted = 1'b0;
              s_nxt.cyc = 5'h0;
              s_nxt.base_init = bank_r[pwdata[base_idx_lsb +: 4]];
              s_nxt.left = pwdata[list_lsb +: 16];
              // Two extra fetches refill the pipeline after a pc load
              s_nxt.fetches = (pwdata[load_bit] && pwdata[pc_index]) ?
                              fetch_pc_count : fetch_count;
              // S without pc load, or any store with S, uses user bank
              s_nxt.user_bank = pwdata[s_bit] &&
                                !(pwdata[load_bit] && pwdata[pc_index]);
              if (pwdata[up_bit]) begin
                start_addr = bank_r[pwdata[base_idx_lsb +: 4]] +
                             (pwdata[pre_bit] ? 32'h4 : 32'h0);
                s_nxt.wb_val = bank_r[pwdata[base_idx_lsb +: 4]] + span;
              end else begin
                start_addr = bank_r[pwdata[base_idx_lsb +: 4]] - span +
                             (pwdata[pre_bit] ? 32'h0 : 32'h4);
                s_nxt.wb_val = bank_r[pwdata[base_idx_lsb +: 4]] - span;
              end
              s_nxt.addr = pwdata[swap_bit] ? bank_r[pwdata[base_idx_lsb +: 4]]
                                            : start_addr;
              s_nxt.phase = pwdata[swap_bit] ? st_swap_rd : st_fetch;
            end
          end
          default: s_nxt.pslverr = 1'b1;
        endcase
      end
    end

    // Instruction sequencing
    unique case (s_r.phase)
      st_idle: begin
      end
      st_fetch: begin
        s_nxt.cyc = s_r.cyc + 5'h1;
        s_nxt.phase = st_xfer;
        s_nxt.mem.req = 1'b1;
        s_nxt.mem.addr = s_r.addr;
        s_nxt.mem.byte_size = 1'b0;
        s_nxt.mem.write = !is_load;
        // First stored word leaves at start of the second cycle: original base
        s_nxt.mem.wdata = bank_r[cur_reg];
      end
      st_xfer: begin
        s_nxt.cyc = s_r.cyc + 5'h1;
        // base updated at end of second cycle (first word)
        if (s_r.cyc == 5'h1 && s_r.ctrl[wb_bit]) begin
          bank_nxt[base_idx] = s_r.wb_val;
        end
        // sample abort on every word, keep the first
        if (abort) begin
          s_nxt.aborted = 1'b1;
        end
        // load only until the first abort; base may be hit
        if (is_load && !abort && !s_r.aborted) begin
          bank_nxt[cur_reg] = mem_rdata; // pc comes last by order
          if (cur_reg == 4'(pc_index) && s_r.ctrl[s_bit]) begin
            s_nxt.cur_stat = s_r.saved_stat;
          end
        end
        s_nxt.left = s_r.left & ~(16'h1 << cur_reg);
        s_nxt.addr = s_r.addr + 32'h4;
        if ((s_r.left & ~(16'h1 << cur_reg)) == 16'h0) begin
          s_nxt.phase = st_internal; // all words first
        end else begin
          s_nxt.mem.req = 1'b1;
          s_nxt.mem.addr = s_r.addr + 32'h4;
          s_nxt.mem.write = !is_load;
          // Later stores see the written-back base
          s_nxt.mem.wdata = bank_nxt[lowest(s_r.left & ~(16'h1 << cur_reg))];
        end
      end
      st_internal: begin
        s_nxt.cyc = s_r.cyc + 5'h1;
        if (is_load && s_r.aborted) begin
          bank_nxt[base_idx] = s_r.ctrl[wb_bit] ? s_r.wb_val : s_r.base_init;
        end
        if (s_r.fetches > 5'h1) begin
          s_nxt.fetches = s_r.fetches - 5'h1; // pc refill fetches
        end else begin
          s_nxt.phase = st_idle;
          s_nxt.trap = s_r.aborted;
          s_nxt.ctrl[go_bit] = 1'b0;
        end
      end
      st_swap_rd: begin
        s_nxt.mem.req = 1'b1;
        s_nxt.mem.lock = 1'b1;
        s_nxt.mem.addr = s_r.addr;
        s_nxt.mem.byte_size = s_r.ctrl[byte_bit];
        s_nxt.phase = st_swap_wr;
      end
      st_swap_wr: begin
        if (!s_r.mem.write) begin
          s_nxt.swap_rd = s_r.ctrl[byte_bit] ? {24'h0, mem_rdata[7:0]}
                                             : mem_rdata;
          s_nxt.aborted = abort;
          s_nxt.mem.req = 1'b1;
          s_nxt.mem.lock = 1'b1;
          s_nxt.mem.write = 1'b1;
          s_nxt.mem.wdata = bank_r[s_r.ctrl[15:12]];
        end else begin
          s_nxt.aborted = s_r.aborted | abort;
          if (!(s_r.aborted | abort)) begin
            bank_nxt[s_r.ctrl[11:8]] = s_r.swap_rd;
          end
          s_nxt.trap = s_r.aborted | abort;
          s_nxt.phase = st_idle;
          s_nxt.ctrl[go_bit] = 1'b0;
        end
      end
    endcase
    // Busy from a flop, so the output carries no decode glitches
    s_nxt.busy = (s_nxt.phase != st_idle);
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      for (int i = 0; i < 16; i++) begin
        bank_r[i] <= word_reset;
      end
    end else begin
      s_r <= s_nxt;
      bank_r <= bank_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign mem_out = s_r.mem;
  assign data_abort_trap = s_r.trap;
  assign busy = s_r.busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence swap_pair_s;
    s_r.mem.lock && !s_r.mem.write ##1 s_r.mem.lock && s_r.mem.write;
  endsequence

  swap_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_r.mem.lock) |-> swap_pair_s)
    else $error("lock not held over read and write");
  swap_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.mem.lock && !s_r.mem.write |=> s_r.mem.addr == $past(s_r.mem.addr))
    else $error("swap write address differs");
  trap_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.trap |-> s_r.phase == st_idle)
    else $error("trap before completion");
  no_load_after_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.aborted && s_r.phase == st_xfer && is_load && cur_reg != base_idx
    |=> bank_r[$past(cur_reg)] == $past(bank_r[cur_reg]))
    else $error("register written after abort");
  wb_second_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.phase == st_xfer && s_r.cyc == 5'h1 && s_r.ctrl[wb_bit] &&
    !(is_load && cur_reg == base_idx) |=> bank_r[base_idx] == s_r.wb_val)
    else $error("base write-back missed");
  abort_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.aborted && s_r.phase == st_xfer |=> s_r.aborted)
    else $error("abort record lost");
  order_up_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.phase == st_xfer && s_r.mem.req ##1 s_r.mem.req && s_r.phase == st_xfer
    |-> s_r.mem.addr == $past(s_r.mem.addr) + 32'h4)
    else $error("addresses not ascending");
  pc_refill_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_r.phase == st_internal) && s_r.fetches == fetch_pc_count
    |-> (s_r.phase == st_internal) [*3] ##1 s_r.phase == st_idle)
    else $error("pc load refill count wrong");
endmodule // block_transfer_swap_unit

// ---- verification/mem_partner.sv ----
/* Memory model behind the sequencer: 64 words, abort on one chosen
   address, writes dropped after an abort. Assumes one clock. */
`timescale 1ns/1ps
module mem_partner (
  // Clock
  input wire logic pclk,
  // Sequencer side
  input wire bts_pkg::mem_req_type mem_out,
  input wire logic trap,
  output logic [31:0] rdata,
  output logic abort,
  // Bench controls
  input wire logic abort_en,
  input wire logic [31:0] abort_addr
);
  import bts_pkg::*;
  logic [31:0] mem [0:63];
  logic [31:0] last_r = 32'h0;
  logic supp_r = 1'b0;
  // Abort may hit any word, read or write alike
  assign abort = mem_out.req && abort_en && mem_out.addr == abort_addr;
  // Idle data lines toggle so stale values never pass for data
  assign rdata = (mem_out.req && !mem_out.write) ? mem[mem_out.addr[7:2]] : ~last_r;
  // Single master: nothing can take the bus during a locked pair
  always @(posedge pclk) begin
    last_r <= rdata;
    if (mem_out.req && mem_out.write && !abort && !supp_r)
      mem[mem_out.addr[7:2]] <= mem_out.wdata;
    if (trap)
      supp_r <= 1'b0;
    else if (abort)
      supp_r <= 1'b1;
  end
endmodule // mem_partner

// ---- verification/test_block_transfer_swap_unit.sv ----
/* Self-checking bench for the block transfer and swap sequencer.
   Assumes mem_partner as the memory and a 125 MHz clock. */
`timescale 1ns/1ps
module test_block_transfer_swap_unit;
  import bts_pkg::*;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, mem_rdata, q;
  logic pready, pslverr, abort, data_abort_trap, busy, e;
  mem_req_type mem_out;
  logic abort_en = 1'b0;
  logic [31:0] abort_addr = 32'h0;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nb, nr, nl, nt, nbyte, t_req, t_trap;

  always #4 pclk = ~pclk;

  block_transfer_swap_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_out(mem_out),
    .mem_rdata(mem_rdata), .abort(abort), .data_abort_trap(data_abort_trap),
    .busy(busy));
  mem_partner mem_model (.pclk(pclk), .mem_out(mem_out), .trap(data_abort_trap),
    .rdata(mem_rdata), .abort(abort), .abort_en(abort_en), .abort_addr(abort_addr));

  // Activity per instruction; cleared by run only while idle
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (busy) nb <= nb + 1;
    if (mem_out.req) nr <= nr + 1;
    if (mem_out.req) t_req <= cyc;
    if (mem_out.req && mem_out.byte_size) nbyte <= nbyte + 1;
    if (mem_out.lock) nl <= nl + 1;
    if (data_abort_trap) nt <= nt + 1;
    if (data_abort_trap) t_trap <= cyc;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic bound(input int i, input int lim);
    if (i >= lim) begin
      n_errors++;
      close_out();
    end
  endtask

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    bound(i, 16);
  endtask

  task automatic set_reg(input logic [3:0] i, input logic [31:0] v);
    apb(1'b1, regsel_off, {28'h0, i});
    apb(1'b1, regval_off, v);
  endtask

  task automatic reg_chk(input logic [3:0] i, input logic [31:0] v);
    apb(1'b1, regsel_off, {28'h0, i});
    apb(1'b0, regval_off, 32'h0);
    chk(q, v);
  endtask

  task automatic fill();
    for (int i = 0; i < 64; i++)
      mem_model.mem[i] = 32'h100 + i;
  endtask

  // Launch one instruction; the trap pulse may trail busy by a cycle
  task automatic run(input logic [15:0] l, input logic [6:0] f, input logic [3:0] b);
    int i;
    {nb, nr, nl, nt, nbyte} = '0;
    apb(1'b1, ctrl_off, {4'h8, b, 1'b0, f, l});
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while ((busy !== 1'b0 || nb == 0) && i < 200);
    repeat (3) @(posedge pclk);
    bound(i, 200);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, ctrl_off, 32'h0);
    chk(q, ctrl_reset);
    apb(1'b0, status_off, 32'h0);
    chk(q, word_reset);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask

  // All eight load codes; with write-back the base joins the list
  task automatic t_modes();
    int n;
    logic [31:0] lo;
    for (int m = 0; m < 8; m++) begin
      n = 2 + m[2];
      lo = m[1] ? 32'h40 + 4 * m[0] : 32'h44 - 4 * n - 4 * m[0];
      fill();
      set_reg(4'h2, 32'h40);
      run(m[2] ? 16'h0007 : 16'h0003, {3'b000, m[2], m[1], m[0], 1'b1}, 4'h2);
      reg_chk(4'h0, 32'h100 + (lo >> 2));
      reg_chk(4'h1, 32'h101 + (lo >> 2));
      reg_chk(4'h2, m[2] ? 32'h102 + (lo >> 2) : 32'h40);
      chk(nr, n);
      chk(nb, n + 2);
    end
  endtask

  task automatic t_store(input logic [3:0] b, input logic ab);
    fill();
    set_reg(4'h1, 32'h11);
    set_reg(4'h2, 32'h22);
    set_reg(4'h5, 32'h55);
    set_reg(b, 32'h40);
    abort_addr = 32'h44;
    abort_en = ab;
    run(16'h0026, 7'h0c, b);
    abort_en = 1'b0;
    chk(mem_model.mem[16], b == 1 ? 32'h40 : 32'h11);
    chk(mem_model.mem[17], ab ? 32'h111 : (b == 2 ? 32'h4c : 32'h22));
    chk(mem_model.mem[18], ab ? 32'h112 : 32'h55);
    reg_chk(b, 32'h4c);
    apb(1'b0, base_off, 32'h0);
    chk(q, 32'h4c);
    chk(nt, {31'h0, ab});
    chk(nr, 3);
    chk(nb, 5);
  endtask

  // Second word aborts in a load of r1, r4 (base), r6 and the pc
  task automatic t_ld_abort(input logic w);
    fill();
    set_reg(4'h1, 32'h1);
    set_reg(4'h6, 32'h6);
    set_reg(4'hf, 32'hf);
    set_reg(4'h4, 32'h40);
    abort_addr = 32'h44;
    abort_en = 1'b1;
    run(16'h8052, {3'b000, w, 3'b101}, 4'h4);
    abort_en = 1'b0;
    reg_chk(4'h1, 32'h110);
    reg_chk(4'h4, w ? 32'h50 : 32'h40);
    reg_chk(4'h6, 32'h6);
    reg_chk(4'hf, 32'hf);
    chk(nt, 1);
    chk({31'h0, t_trap > t_req}, 32'h1);
    chk(nb, 8);
  endtask

  // Word swap with one register as source and destination; byte swap aborts
  task automatic t_swap(input logic byt);
    fill();
    set_reg(4'h2, 32'h40);
    set_reg(4'h3, 32'hcafe);
    abort_addr = 32'h40;
    abort_en = byt;
    run(16'h3300, {1'b1, byt, 5'h00}, 4'h2);
    abort_en = 1'b0;
    chk(nl, 2);
    chk(nr, 2);
    chk(nt, {31'h0, byt});
    chk(nbyte, byt ? 2 : 0);
    if (!byt) begin
      chk(mem_model.mem[16], 32'hcafe);
      reg_chk(4'h3, 32'h110);
      apb(1'b0, result_off, 32'h0);
      chk(q, 32'h110);
    end
  endtask

  task automatic t_sbit();
    fill();
    set_reg(4'h2, 32'h40);
    apb(1'b1, saved_off, 32'h5a);
    run(16'h8000, 7'h15, 4'h2);
    apb(1'b0, curstat_off, 32'h0);
    chk(q, 32'h5a);
    reg_chk(4'hf, 32'h110);
    chk(nb, 5);
    run(16'h0002, 7'h14, 4'h2);
    apb(1'b0, status_off, 32'h0);
    chk({31'h0, q[2]}, 32'h1);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_store(4'h2, 1'b0);
    t_store(4'h1, 1'b0);
    t_store(4'h2, 1'b1);
    t_ld_abort(1'b0);
    t_ld_abort(1'b1);
    t_swap(1'b0);
    t_swap(1'b1);
    t_sbit();
    close_out();
  end
endmodule // test_block_transfer_swap_unit
